// File: common/pesc_defines.svh
`ifndef PESC_DEFINES_SVH
`define PESC_DEFINES_SVH

// Event codes
`define PESC_EVT_LOAD_RETIRED   8'hcb
`define PESC_EVT_FP_TRANS       8'hcc
`define PESC_EVT_ASSIST         8'hcd
`define PESC_EVT_SIMD_RETIRED   8'hce
`define PESC_EVT_SAT_RETIRED    8'hcf
`define PESC_EVT_RAT_STALL      8'hd2

// Unit masks
`define PESC_UM_L2_LINE_MISS    8'h08
`define PESC_UM_DTLB_MISS       8'h10
`define PESC_UM_TO_PACKED_INT   8'h01
`define PESC_UM_TO_FP           8'h02
`define PESC_UM_NONE            8'h00
`define PESC_UM_ROB_READ_PORT   8'h01

// Widths and reset values
`define PESC_CNT_W              40
`define PESC_LANES              4
`define PESC_LANE_W             3
`define PESC_CNT_RESET          40'h00_0000_0000
`define PESC_ADDR_W             48
`define PESC_ADDR_RESET         48'h0000_0000_0000

`endif

// File: common/pesc_pkg.sv
`default_nettype none
package pesc_pkg;
	// Selected event after decode
	typedef enum logic [7:0] {
		PESC_SEL_NONE      = 8'h00,
		PESC_SEL_L2_MISS   = 8'h01,
		PESC_SEL_DTLB_MISS = 8'h02,
		PESC_SEL_TO_PI     = 8'h04,
		PESC_SEL_TO_FP     = 8'h08,
		PESC_SEL_ASSIST    = 8'h10,
		PESC_SEL_SIMD      = 8'h20,
		PESC_SEL_SAT       = 8'h40,
		PESC_SEL_ROB_STALL = 8'h80
	} pesc_sel_t;
	// Instruction class tracked for state transitions
	typedef enum logic [1:0] {
		PESC_ST_FP = 2'h1,
		PESC_ST_PI = 2'h2
	} pesc_state_t;
endpackage
`default_nettype wire

// File: dv/perf_event_select_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pesc_defines.svh"

module perf_event_select_counter_tb;
	logic                           clk = 1'b0;
	logic                           resetn = 1'b0;
	logic                           en = 1'b1;
	logic                           first = 1'b1;
	logic [7:0]                     code = 8'h00;
	logic [7:0]                     mask = 8'h00;
	logic [9:0][`PESC_LANES-1:0]    attr, attr_n;
	logic [4:0]                     misc, misc_n;
	logic [`PESC_ADDR_W-1:0]        ip, ip_n, sample_addr;
	logic [`PESC_CNT_W-1:0]         count, prev, total, e;
	logic                           sample_valid, en_n, first_n;
	logic [1:0]                     hist;
	logic [`PESC_CNT_W-1:0]         exp_q[$];
	logic [`PESC_ADDR_W-1:0]        smp_q[$];
	logic [15:0]                    modes[11] = '{16'hcc01, 16'hcc02, 16'hcb08, 16'hcb10,
		16'hcd00, 16'hce00, 16'hcf00, 16'hd201, 16'hcb04, 16'hce01, 16'hd200};
	int                             n_errors = 0;
	int                             n_tests = 0;
	int unsigned                    d;
	bit                             smp;

	// Core clock, 100 ns period
	always #50 clk = ~clk;

	pesc_core_model model (.clk(clk), .attr(attr), .misc(misc), .next_ip(ip));

	pesc_counter dut (.clk(clk), .resetn(resetn), .enable(en), .is_first_counter(first),
		.event_code(code), .unit_mask(mask), .retire_valid(attr[0]), .is_load(attr[1]),
		.cacheable(attr[2]), .sw_prefetch(attr[3]), .blocked(attr[4]), .faulted(attr[5]),
		.l2_line_miss_bus(attr[6]), .dtlb_miss(attr[7]), .packed_int(attr[8]),
		.saturating(attr[9]), .next_ip(ip), .fp_issue(misc[0]), .packed_int_issue(misc[1]),
		.state_empty_exec(misc[2]), .state_altered(misc[3]),
		.reorder_read_port_stall(misc[4]), .count(count), .sample_valid(sample_valid),
		.sample_addr(sample_addr));

	task automatic fail(input string msg);
		$display("[FAIL] %0t %s", $time, msg);
		n_errors++;
	endtask

	task automatic give_verdict();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hits the selection should yield for the values about to be driven
	function automatic int unsigned expect_hits(input logic [15:0] sel, input logic f,
		output bit s);
		int unsigned n;
		logic ld;
		n = 0;
		for (int i = 0; i < `PESC_LANES; i++) begin
			ld = attr_n[0][i] & attr_n[1][i] & attr_n[2][i] & ~attr_n[3][i];
			case (sel)
				16'hcb08: n += f & ld & ~attr_n[4][i] & attr_n[6][i];
				16'hcb10: n += f & ld & ~attr_n[5][i] & attr_n[7][i];
				16'hce00: n += attr_n[0][i] & attr_n[8][i];
				16'hcf00: n += attr_n[0][i] & attr_n[9][i];
				16'hcc01: n += (i == 0) & misc_n[1] & (hist == 2'h1);
				16'hcc02: n += (i == 0) & misc_n[0] & (hist == 2'h2);
				16'hcd00: n += (i == 0) & misc_n[2] & misc_n[3];
				16'hd201: n += (i == 0) & misc_n[4];
				default: n += 0;
			endcase
		end
		s = (n != 0) && (sel[15:8] == 8'hcb);
		return n;
	endfunction

	// Each change of count retires the oldest expected total
	always @(posedge clk) begin
		if (resetn === 1'b1 && count !== prev) begin
			if (exp_q.size() == 0) begin
				fail("count moved with nothing expected");
			end else begin
				e = exp_q.pop_front();
				n_tests++;
				if (count !== e) fail("count differs from expected total");
			end
		end
		if (resetn === 1'b1 && sample_valid === 1'b1) begin
			n_tests++;
			if (smp_q.size() == 0) fail("sample with no load hit");
			else if (sample_addr !== smp_q.pop_front()) fail("wrong sample address");
		end
		prev = count;
	end

	// Random traffic, mode by mode; transition modes first, enable held high there
	initial begin
		void'($urandom(12));
		total = '0;
		hist = 2'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		n_tests++;
		if (count !== `PESC_CNT_RESET || sample_valid !== 1'b0
			|| sample_addr !== `PESC_ADDR_RESET) fail("bad reset state");
		foreach (modes[j]) begin
			model.idle();
			code <= modes[j][15:8];
			mask <= modes[j][7:0];
			repeat (30) begin
				for (int k = 0; k < 10; k++) begin
					attr_n[k] = 4'($urandom);
					if (k inside {1, 2, 6, 7}) attr_n[k] |= 4'($urandom);
					if (k inside {3, 4, 5}) attr_n[k] &= 4'($urandom);
				end
				misc_n = 5'($urandom);
				ip_n = {16'($urandom), 32'($urandom)};
				en_n = (j < 2) || ($urandom % 6 != 0);
				first_n = ($urandom % 5 != 0);
				d = expect_hits(modes[j], first_n, smp);
				if (en_n && d != 0) begin
					total += d;
					exp_q.push_back(total);
				end
				if (en_n && smp) smp_q.push_back(ip_n);
				if (misc_n[0]) hist = 2'h1;
				else if (misc_n[1]) hist = 2'h2;
				model.drive(attr_n, misc_n, ip_n);
				en <= en_n;
				first <= first_n;
			end
		end
		repeat (4) model.idle();
		@(negedge clk);
		n_tests++;
		if (exp_q.size() != 0 || smp_q.size() != 0 || count !== total) fail("results missing");
		give_verdict();
	end

	// Watchdog, far beyond the few hundred cycles of traffic
	initial begin
		#200000;
		n_errors++;
		give_verdict();
	end
endmodule // perf_event_select_counter_tb
`default_nettype wire

// File: dv/pesc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "pesc_defines.svh"

// Core pipeline stand-in: one cycle of lane and issue events per call
module pesc_core_model (
	input  wire logic                              clk,
	output logic [9:0][`PESC_LANES-1:0]            attr,
	output logic [4:0]                             misc,
	output logic [`PESC_ADDR_W-1:0]                next_ip
);
	// Quiet lines at time zero
	initial begin
		attr = '0;
		misc = 5'h00;
		next_ip = '0;
	end

	// Present one retirement cycle, held until the next edge
	task automatic drive(input logic [9:0][`PESC_LANES-1:0] a, input logic [4:0] m,
		input logic [`PESC_ADDR_W-1:0] ip);
		@(posedge clk);
		attr <= a;
		misc <= m;
		next_ip <= ip;
	endtask

	// No retirement: qualifiers flip so stale values cannot pass for real ones
	task automatic idle();
		@(posedge clk);
		attr <= {~attr[9:1], {`PESC_LANES{1'b0}}};
		misc <= 5'h00;
		next_ip <= ~next_ip;
	endtask
endmodule // pesc_core_model
`default_nettype wire

// File: hw/pesc_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "pesc_defines.svh"

module pesc_counter
	import pesc_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire logic                        enable,
	input  wire logic                        is_first_counter,
	input  wire logic [7:0]                  event_code,
	input  wire logic [7:0]                  unit_mask,
	input  wire logic [`PESC_LANES-1:0]      retire_valid,
	input  wire logic [`PESC_LANES-1:0]      is_load,
	input  wire logic [`PESC_LANES-1:0]      cacheable,
	input  wire logic [`PESC_LANES-1:0]      sw_prefetch,
	input  wire logic [`PESC_LANES-1:0]      blocked,
	input  wire logic [`PESC_LANES-1:0]      faulted,
	input  wire logic [`PESC_LANES-1:0]      l2_line_miss_bus,
	input  wire logic [`PESC_LANES-1:0]      dtlb_miss,
	input  wire logic [`PESC_LANES-1:0]      packed_int,
	input  wire logic [`PESC_LANES-1:0]      saturating,
	input  wire logic [`PESC_ADDR_W-1:0]     next_ip,
	input  wire logic                        fp_issue,
	input  wire logic                        packed_int_issue,
	input  wire logic                        state_empty_exec,
	input  wire logic                        state_altered,
	input  wire logic                        reorder_read_port_stall,
	output logic [`PESC_CNT_W-1:0]           count,
	output logic                             sample_valid,
	output logic [`PESC_ADDR_W-1:0]          sample_addr
);
	pesc_sel_t                  sel;
	logic [`PESC_LANES-1:0]     lane_hit;
	logic [`PESC_LANE_W-1:0]    lane_sum;
	logic                       single_hit;
	logic                       load_event;
	logic                       allowed;
	logic                       last_fp_reg;
	logic                       last_pi_reg;
	logic                       seen_reg;
	logic [`PESC_CNT_W-1:0]     count_reg;
	logic [`PESC_CNT_W-1:0]     count_next;
	logic                       sample_valid_reg;
	logic [`PESC_ADDR_W-1:0]    sample_addr_reg;

	// Decode needs code and mask both to match
	always_comb begin
		sel = PESC_SEL_NONE;
		if (event_code == `PESC_EVT_LOAD_RETIRED && unit_mask == `PESC_UM_L2_LINE_MISS) begin
			sel = PESC_SEL_L2_MISS;
		end else if (event_code == `PESC_EVT_LOAD_RETIRED
			&& unit_mask == `PESC_UM_DTLB_MISS) begin
			sel = PESC_SEL_DTLB_MISS;
		end else if (event_code == `PESC_EVT_FP_TRANS && unit_mask == `PESC_UM_TO_PACKED_INT) begin
			sel = PESC_SEL_TO_PI;
		end else if (event_code == `PESC_EVT_FP_TRANS && unit_mask == `PESC_UM_TO_FP) begin
			sel = PESC_SEL_TO_FP;
		end else if (event_code == `PESC_EVT_ASSIST && unit_mask == `PESC_UM_NONE) begin
			sel = PESC_SEL_ASSIST;
		end else if (event_code == `PESC_EVT_SIMD_RETIRED && unit_mask == `PESC_UM_NONE) begin
			sel = PESC_SEL_SIMD;
		end else if (event_code == `PESC_EVT_SAT_RETIRED && unit_mask == `PESC_UM_NONE) begin
			sel = PESC_SEL_SAT;
		end else if (event_code == `PESC_EVT_RAT_STALL
			&& unit_mask == `PESC_UM_ROB_READ_PORT) begin
			sel = PESC_SEL_ROB_STALL;
		end
	end

	// Load miss events are only honoured on the first counter
	assign load_event = (sel == PESC_SEL_L2_MISS) || (sel == PESC_SEL_DTLB_MISS);
	assign allowed    = enable && (!load_event || is_first_counter);

	// One qualifier per retirement lane
	genvar g;
	generate
		for (g = 0; g < `PESC_LANES; g++) begin : g_lane
			pesc_lane_qual u_qual (
				.retire_valid     (retire_valid[g]),
				.sel              (sel),
				.is_load          (is_load[g]),
				.cacheable        (cacheable[g]),
				.sw_prefetch      (sw_prefetch[g]),
				.blocked          (blocked[g]),
				.faulted          (faulted[g]),
				.l2_line_miss_bus (l2_line_miss_bus[g]),
				.dtlb_miss        (dtlb_miss[g]),
				.packed_int       (packed_int[g]),
				.saturating       (saturating[g]),
				.hit              (lane_hit[g])
			);
		end
	endgenerate

	// Population count so same-cycle hits are all added
	always_comb begin
		lane_sum = '0;
		for (int i = 0; i < `PESC_LANES; i++) begin
			lane_sum = lane_sum + {{(`PESC_LANE_W-1){1'b0}}, lane_hit[i]};
		end
	end

	// Non-lane events: at most one per cycle each
	always_comb begin
		case (sel)
			PESC_SEL_TO_PI:     single_hit = packed_int_issue && seen_reg && last_fp_reg;
			PESC_SEL_TO_FP:     single_hit = fp_issue && seen_reg && last_pi_reg;
			PESC_SEL_ASSIST:    single_hit = state_empty_exec && state_altered;
			PESC_SEL_ROB_STALL: single_hit = reorder_read_port_stall;
			default:            single_hit = 1'b0;
		endcase
	end

	// Last instruction class, tracked regardless of selection
	always_ff @(posedge clk) begin
		if (!resetn) begin
			last_fp_reg <= 1'b0;
			last_pi_reg <= 1'b0;
			seen_reg    <= 1'b0;
		end else if (fp_issue) begin
			last_fp_reg <= 1'b1;
			last_pi_reg <= 1'b0;
			seen_reg    <= 1'b1;
		end else if (packed_int_issue) begin
			last_fp_reg <= 1'b0;
			last_pi_reg <= 1'b1;
			seen_reg    <= 1'b1;
		end
	end

	// Wide counter: wrap is harmless at this width
	assign count_next = count_reg
		+ {{(`PESC_CNT_W-`PESC_LANE_W){1'b0}}, lane_sum}
		+ {{(`PESC_CNT_W-1){1'b0}}, single_hit};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			count_reg <= `PESC_CNT_RESET;
		end else if (allowed) begin
			count_reg <= count_next;
		end
	end

	// Precise sample keeps the address of the following instruction
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sample_valid_reg <= 1'b0;
			sample_addr_reg  <= `PESC_ADDR_RESET;
		end else begin
			sample_valid_reg <= allowed && load_event && (lane_hit != '0);
			if (allowed && load_event && (lane_hit != '0)) begin
				sample_addr_reg <= next_ip;
			end
		end
	end

	assign count        = count_reg;
	assign sample_valid = sample_valid_reg;
	assign sample_addr  = sample_addr_reg;

	// Stall cycle adds exactly one
	property p_stall_count;
		@(posedge clk) disable iff (!resetn)
		(allowed && sel == PESC_SEL_ROB_STALL && reorder_read_port_stall)
		|=> count == $past(count) + 1;
	endproperty
	a_stall_count: assert property (p_stall_count) else $error("stall cycle not counted");

	// Persisting stall counts on consecutive cycles
	property p_stall_repeat;
		@(posedge clk) disable iff (!resetn)
		(allowed && sel == PESC_SEL_ROB_STALL && reorder_read_port_stall) [*2]
		|=> count == $past(count, 2) + 2;
	endproperty
	a_stall_repeat: assert property (p_stall_repeat) else $error("retry stall missed");

	// Mismatched selection never counts
	property p_no_match;
		@(posedge clk) disable iff (!resetn)
		(sel == PESC_SEL_NONE) |=> count == $past(count);
	endproperty
	a_no_match: assert property (p_no_match) else $error("count without match");

	// All lane hits added
	property p_multi;
		@(posedge clk) disable iff (!resetn)
		(allowed && sel == PESC_SEL_SIMD)
		|=> count == $past(count) + $countones($past(retire_valid & packed_int));
	endproperty
	a_multi: assert property (p_multi) else $error("lane hits lost");

	// Prefetch or uncacheable loads never hit, lane by lane so mixed cycles are covered
	property p_prefetch;
		@(posedge clk) disable iff (!resetn)
		(sel == PESC_SEL_L2_MISS || sel == PESC_SEL_DTLB_MISS)
		|-> (lane_hit & (sw_prefetch | ~cacheable)) == '0;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("excluded load counted");

	// Faulting DTLB misses are dropped on every lane
	property p_fault;
		@(posedge clk) disable iff (!resetn)
		(sel == PESC_SEL_DTLB_MISS)
		|-> (lane_hit & faulted) == '0;
	endproperty
	a_fault: assert property (p_fault) else $error("faulted miss counted");

	// L2 line miss counted when lane 0 qualifies
	property p_l2;
		@(posedge clk) disable iff (!resetn)
		(allowed && sel == PESC_SEL_L2_MISS && retire_valid[0] && is_load[0] && cacheable[0]
			&& !sw_prefetch[0] && !blocked[0] && l2_line_miss_bus[0])
		|=> count > $past(count);
	endproperty
	a_l2: assert property (p_l2) else $error("l2 line miss not counted");

	// Sample address follows the event
	property p_sample;
		@(posedge clk) disable iff (!resetn)
		(allowed && load_event && lane_hit != '0)
		|=> sample_valid && sample_addr == $past(next_ip);
	endproperty
	a_sample: assert property (p_sample) else $error("sample address wrong");

	// Transition counts only after floating point
	property p_to_pi;
		@(posedge clk) disable iff (!resetn)
		(allowed && sel == PESC_SEL_TO_PI && packed_int_issue && !last_fp_reg)
		|=> count == $past(count);
	endproperty
	a_to_pi: assert property (p_to_pi) else $error("false transition");
endmodule // pesc_counter

`default_nettype wire

// File: hw/pesc_lane_qual.sv
`timescale 1ns/1ps
`default_nettype none
`include "pesc_defines.svh"

// Qualifies one retirement lane against the selected event
module pesc_lane_qual
	import pesc_pkg::*;
(
	input  wire logic      retire_valid,
	input  wire pesc_sel_t sel,
	input  wire logic      is_load,
	input  wire logic      cacheable,
	input  wire logic      sw_prefetch,
	input  wire logic      blocked,
	input  wire logic      faulted,
	input  wire logic      l2_line_miss_bus,
	input  wire logic      dtlb_miss,
	input  wire logic      packed_int,
	input  wire logic      saturating,
	output logic           hit
);
	logic load_ok;

	// Only cacheable, non-prefetch loads qualify
	assign load_ok = retire_valid && is_load && cacheable && !sw_prefetch;

	// Blocked loads dropped from L2 line misses only: allowed undercount keeps the path simple
	always_comb begin
		case (sel)
			PESC_SEL_L2_MISS:   hit = load_ok && l2_line_miss_bus && !blocked;
			PESC_SEL_DTLB_MISS: hit = load_ok && dtlb_miss && !faulted;
			PESC_SEL_SIMD:      hit = retire_valid && packed_int;
			PESC_SEL_SAT:       hit = retire_valid && saturating;
			default:            hit = 1'b0;
		endcase
	end
endmodule // pesc_lane_qual

`default_nettype wire
